// ===== hdl/dac_load_ctrl.sv
// serial frame receiver, readback shifter and dac load control
`timescale 1ns/1ns
module dac_load_ctrl
  import dac_load_pkg::*;
(
  input  wire logic        mclk_i,              // 100 mhz system clock
  input  wire logic        sys_rst_i,           // sync reset, active high
  input  wire logic        ce_i,                // freezes all state when low
  input  wire logic        sclk_i,              // serial clock pin
  input  wire logic        frame_sel_n_i,       // frame select pin
  input  wire logic        serial_in_i,         // serial data pin
  input  wire logic        load_output_n_i,     // load strobe pin
  input  wire logic        clear_to_preset_n_i, // clear pin
  input  wire logic        dev_reset_n_i,       // device reset pin
  output logic             serial_out_o,        // serial data out
  output logic             serial_out_oe_o,     // high while driving
  output logic [19:0]      dac_code_o,          // dac register
  output logic [19:0]      line_code_o,         // code as straight binary
  output logic             twos_mode_o,         // coding select
  output logic             dac_update_o,        // one-cycle update pulse
  output logic             word_space_o         // buffer can take a word
);
  typedef enum logic {FR_IDLE, FR_SHIFT} frame_state_type;

  pins_type        pins_raw;            // pin bundle
  pins_type        sync1_q, sync2_q;    // two-stage synchroniser
  pins_type        prev_q;              // delayed copy for edges
  logic            sclk_fall, sclk_rise;
  logic            frame_start, frame_end, load_fall, clr_fall;
  logic            dev_rst;             // reset pin, synchronised

  frame_state_type st_q, st_d;          // frame state
  logic [23:0]     shift_q, shift_d;    // input shift register
  logic [4:0]      cnt_q, cnt_d;        // bits seen this frame
  logic [23:0]     out_q, out_d;        // readback shifter
  logic            sdo_q, sdo_d;        // serial out flop
  logic            oe_q, oe_d;          // output enable flop
  logic            push;                // complete word at frame end

  logic            fifo_valid, fifo_ready;
  logic [23:0]     fifo_data;
  cmd_word_type    word;                // word leaving the buffer
  logic            pop;                 // word applied this cycle

  logic [19:0]     in_q, in_d;          // input register
  logic [19:0]     dac_q, dac_d;        // dac register
  logic [19:0]     ctrl_q, ctrl_d;      // control register
  logic [19:0]     clrc_q, clrc_d;      // clear code register
  logic [19:0]     line_q, line_d;      // coded output
  logic            pend_q, pend_d;      // update waiting for strobe
  logic            upd_q, upd_d;        // update pulse
  logic [23:0]     rb_q, rb_d;          // readback word for next frame

  assign pins_raw = '{sclk: sclk_i, frame_n: frame_sel_n_i,
                      sdi: serial_in_i, load_n: load_output_n_i,
                      clr_n: clear_to_preset_n_i, rst_n: dev_reset_n_i};

  // pins are asynchronous: two flops, then a third for edge finding
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      sync1_q <= PINS_IDLE;
      sync2_q <= PINS_IDLE;
      prev_q  <= PINS_IDLE;
    end
    else if (ce_i)
    begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // edges seen only on the settled stages
  assign sclk_fall   = prev_q.sclk && !sync2_q.sclk;
  assign sclk_rise   = !prev_q.sclk && sync2_q.sclk;
  assign frame_start = prev_q.frame_n && !sync2_q.frame_n;
  assign frame_end   = !prev_q.frame_n && sync2_q.frame_n;
  assign load_fall   = prev_q.load_n && !sync2_q.load_n;
  assign clr_fall    = prev_q.clr_n && !sync2_q.clr_n;
  assign dev_rst     = !sync2_q.rst_n;

  // frame receiver and readback shifter, next values
  always_comb
  begin
    st_d    = st_q;
    shift_d = shift_q;
    cnt_d   = cnt_q;
    out_d   = out_q;
    sdo_d   = sdo_q;
    oe_d    = oe_q;
    push    = 1'b0;
    case (st_q)
      FR_IDLE:
      begin
        // clock activity outside a frame is ignored
        if (frame_start)
        begin
          st_d  = FR_SHIFT;
          cnt_d = '0;
          out_d = rb_q;
          oe_d  = 1'b1;
        end
      end
      FR_SHIFT:
      begin
        if (frame_end)
        begin
          st_d = FR_IDLE;
          oe_d = 1'b0;
          // short or long frames are dropped, not half applied
          push = (cnt_q == BITS_PER_WORD);
        end
        else
        begin
          if (sclk_fall)
          begin
            shift_d = {shift_q[22:0], sync2_q.sdi};
            cnt_d   = (cnt_q == BITS_SAT) ? cnt_q : cnt_q + 1'b1;
          end
          if (sclk_rise)
          begin
            sdo_d = out_q[23];
            out_d = {out_q[22:0], 1'b0};
          end
        end
      end
      default:
        st_d = FR_IDLE;
    endcase
    if (dev_rst)
    begin
      st_d    = FR_IDLE;
      shift_d = WORD_RST;
      cnt_d   = '0;
      out_d   = WORD_RST;
      sdo_d   = 1'b0;
      oe_d    = 1'b0;
      push    = 1'b0;
    end
  end

  // frame receiver registers
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      st_q    <= FR_IDLE;
      shift_q <= WORD_RST;
      cnt_q   <= '0;
      out_q   <= WORD_RST;
      sdo_q   <= 1'b0;
      oe_q    <= 1'b0;
    end
    else if (ce_i)
    begin
      st_q    <= st_d;
      shift_q <= shift_d;
      cnt_q   <= cnt_d;
      out_q   <= out_d;
      sdo_q   <= sdo_d;
      oe_q    <= oe_d;
    end
  end

  // words wait here while a clear is held; a full buffer drops frames
  word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .sys_rst_i   (sys_rst_i || (ce_i && dev_rst)),
    .ce_i        (ce_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (shift_q),
    .out_valid_o (fifo_valid),
    .out_ready_i (sync2_q.clr_n),
    .out_data_o  (fifo_data)
  );

  assign word = fifo_data;
  assign pop  = fifo_valid && sync2_q.clr_n;

  // register file and load control, next values
  always_comb
  begin
    in_d   = in_q;
    dac_d  = dac_q;
    ctrl_d = ctrl_q;
    clrc_d = clrc_q;
    pend_d = pend_q;
    rb_d   = rb_q;
    upd_d  = 1'b0;
    if (pop && word.rd)
    begin
      // unmapped addresses read back as zero
      rb_d = {word.rd, word.addr, 20'h00000};
      case (word.addr)
        ADDR_DAC:  rb_d[19:0] = dac_q;
        ADDR_CTRL: rb_d[19:0] = ctrl_q;
        ADDR_CLR:  rb_d[19:0] = clrc_q;
        default:   rb_d[19:0] = 20'h00000;
      endcase
    end
    else if (pop)
    begin
      case (word.addr)
        ADDR_DAC:
        begin
          in_d = word.data;
          if (!sync2_q.load_n)
          begin
            dac_d  = word.data;
            upd_d  = 1'b1;
            pend_d = 1'b0;
          end
          else
            pend_d = 1'b1;
        end
        ADDR_CTRL: ctrl_d = word.data;
        ADDR_CLR:  clrc_d = word.data;
        default:   ctrl_d = ctrl_q;
      endcase
    end
    // strobe fall moves the input register across
    if (load_fall)
    begin
      dac_d  = in_d;
      upd_d  = 1'b1;
      pend_d = 1'b0;
    end
    // clear wins over any load while held
    if (!sync2_q.clr_n)
    begin
      dac_d = clrc_q;
      upd_d = upd_d || clr_fall;
    end
    if (dev_rst)
    begin
      in_d   = DAC_RST;
      dac_d  = DAC_RST;
      ctrl_d = CTRL_RST;
      clrc_d = CLR_RST;
      pend_d = 1'b0;
      rb_d   = WORD_RST;
      upd_d  = 1'b0;
    end
    // two's complement flips the sign bit to reach straight binary
    line_d = dac_d;
    if (ctrl_d[CTRL_TWOS])
      line_d[DATA_MSB] = !dac_d[DATA_MSB];
  end

  // register file
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      in_q   <= DAC_RST;
      dac_q  <= DAC_RST;
      ctrl_q <= CTRL_RST;
      clrc_q <= CLR_RST;
      line_q <= DAC_RST;
      pend_q <= 1'b0;
      upd_q  <= 1'b0;
      rb_q   <= WORD_RST;
    end
    else if (ce_i)
    begin
      in_q   <= in_d;
      dac_q  <= dac_d;
      ctrl_q <= ctrl_d;
      clrc_q <= clrc_d;
      line_q <= line_d;
      pend_q <= pend_d;
      upd_q  <= upd_d;
      rb_q   <= rb_d;
    end
  end

  assign serial_out_o    = sdo_q;
  assign serial_out_oe_o = oe_q;
  assign dac_code_o      = dac_q;
  assign line_code_o     = line_q;
  assign twos_mode_o     = ctrl_q[CTRL_TWOS];
  assign dac_update_o    = upd_q;
  assign word_space_o    = fifo_ready;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i || !ce_i);

  // the reset pin may clear the idle shifter, so it is left out here
  a_idle_no_shift: assert property ((st_q == FR_IDLE && !dev_rst)
      |=> $stable(shift_q))
    else $error("shift register moved outside a frame");
  a_fall_capture: assert property ((st_q == FR_SHIFT && sclk_fall
      && !frame_end && !dev_rst) |=> shift_q[0] == $past(sync2_q.sdi))
    else $error("falling edge did not capture input bit");
  a_word_length: assert property (push |-> cnt_q == BITS_PER_WORD)
    else $error("word accepted with wrong bit count");
  a_end_accept: assert property ((st_q == FR_SHIFT && frame_end && !dev_rst
      && cnt_q == BITS_PER_WORD) |-> push)
    else $error("full frame not accepted at frame end");
  a_rise_drive: assert property ((st_q == FR_SHIFT && sclk_rise
      && !frame_end && !dev_rst) |=> serial_out_o == $past(out_q[23]))
    else $error("output bit not driven on rising edge");
  a_load_low_upd: assert property ((pop && !word.rd && word.addr == ADDR_DAC
      && !sync2_q.load_n && !dev_rst)
      |=> dac_q == $past(word.data) && dac_update_o)
    else $error("held load did not update dac");
  a_load_defer: assert property ((pop && !word.rd && word.addr == ADDR_DAC
      && sync2_q.load_n && !dev_rst) |=> $stable(dac_q) && pend_q)
    else $error("dac changed without load strobe");
  a_clear_load: assert property ((!sync2_q.clr_n && !dev_rst)
      |=> dac_q == $past(clrc_q))
    else $error("clear did not load clear code");
  a_coding_map: assert property (##1 line_code_o == (twos_mode_o ?
      {!dac_q[DATA_MSB], dac_q[18:0]} : dac_q))
    else $error("coded output disagrees with coding select");
  a_reset_pin: assert property (dev_rst |=> dac_q == DAC_RST
      && st_q == FR_IDLE && !serial_out_oe_o)
    else $error("reset pin did not restore power-on state");
  a_out_release: assert property (frame_end |=> !serial_out_oe_o)
    else $error("output still driven after frame end");

  c_word_push:  cover property (push);
  c_defer_load: cover property (pend_q ##[1:200] load_fall);
  c_clear:      cover property (clr_fall && dac_update_o == 1'b0);
  c_readback:   cover property (pop && word.rd);
endmodule

// ===== hdl/dac_load_pkg.sv
// shared constants and carriers for the serial dac load control block
package dac_load_pkg;
  localparam int       WORD_W     = 24;      // bits per serial frame
  localparam int       DATA_W     = 20;      // dac code width
  localparam int       FIFO_DEPTH = 8;       // words buffered after frames
  localparam logic [4:0] BITS_PER_WORD = 5'h18;  // 24 captured bits
  localparam logic [4:0] BITS_SAT      = 5'h1f;  // counter ceiling
  localparam logic [2:0] ADDR_DAC   = 3'h1;  // input / dac register
  localparam logic [2:0] ADDR_CTRL  = 3'h2;  // control register
  localparam logic [2:0] ADDR_CLR   = 3'h3;  // clear code register
  localparam int       CTRL_TWOS  = 1;       // coding select bit
  localparam int       DATA_MSB   = 19;      // sign bit of the code
  localparam logic [19:0] DAC_RST   = 20'h00000;  // dac power-on code
  localparam logic [19:0] CTRL_RST  = 20'h00000;  // binary coding
  localparam logic [19:0] CLR_RST   = 20'h00000;  // clear code default
  localparam logic [23:0] WORD_RST  = 24'h000000; // empty frame word

  // pins from the host side, all outside the mclk domain
  typedef struct packed {
    logic sclk;     // serial clock
    logic frame_n;  // frame select, active low
    logic sdi;      // serial data in
    logic load_n;   // load strobe, active low
    logic clr_n;    // clear to preset, active low
    logic rst_n;    // device reset, active low
  } pins_type;

  // sclk idles low so no false edge follows reset; load idles low
  localparam pins_type PINS_IDLE = 6'h13;  // idle levels, sdi low

  // one received frame
  typedef struct packed {
    logic        rd;    // readback request
    logic [2:0]  addr;  // target register
    logic [19:0] data;  // payload
  } cmd_word_type;
endpackage

// ===== hdl/word_fifo.sv
// small synchronous fifo between the frame receiver and the register logic
`timescale 1ns/1ns
module word_fifo #(
  parameter int WIDTH = 24,  // word width
  parameter int DEPTH = 8    // entries, power of two
) (
  input  wire logic             mclk_i,     // system clock
  input  wire logic             sys_rst_i,  // sync reset
  input  wire logic             ce_i,       // clock enable
  input  wire logic             in_valid_i, // word offered
  output logic                  in_ready_o, // space left
  input  wire logic [WIDTH-1:0] in_data_i,  // word in
  output logic                  out_valid_o,// word waiting
  input  wire logic             out_ready_i,// drain accepts
  output logic [WIDTH-1:0]      out_data_o  // word out
);
  localparam int AW = $clog2(DEPTH);  // index width; pointers carry one more bit

  logic [WIDTH-1:0] mem_q [DEPTH];  // storage
  logic [AW:0]      wr_q, wr_d;     // write pointer, wrap bit on top
  logic [AW:0]      rd_q, rd_d;     // read pointer
  logic             push, pop;      // accepted moves

  // full when pointers differ only in the wrap bit
  assign in_ready_o  = !((wr_q[AW] != rd_q[AW])
                         && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid_o = (wr_q != rd_q);
  assign out_data_o  = mem_q[rd_q[AW-1:0]];

  // next pointers
  always_comb
  begin
    push = in_valid_i && in_ready_o;
    pop  = out_valid_o && out_ready_i;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  // pointers and storage
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else if (ce_i)
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      if (push)
        mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// ===== sim/host_serial_model.sv
// behavioural host serial controller that frames words into the block
`timescale 1ns/1ns
module host_serial_model (
  input  wire logic mclk_i,          // pacing clock
  output logic      sclk_o,          // serial clock, toggled between frames only by noise
  output logic      frame_sel_n_o,   // frame select, active low
  output logic      serial_in_o,     // data towards the block
  input  wire logic serial_out_i,    // data from the block
  input  wire logic serial_out_oe_i  // block drives serial_out
);
  initial
  begin
    sclk_o = 1'b0;
    frame_sel_n_o = 1'b1;
    serial_in_o = 1'b0;
  end

  // wait n system clock edges
  task automatic ticks(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  // clock activity outside a frame, which must be ignored
  task automatic noise();
    repeat (6)
    begin
      sclk_o <= ~sclk_o;
      serial_in_o <= ~serial_in_o;
      ticks(4);
    end
    sclk_o <= 1'b0;
    ticks(4);
  endtask

  // one frame, msb first, 80 ns serial period, well under both limits
  task automatic send(input logic [23:0] word, input int nbits,
                      output logic [23:0] rd, output logic oe_mid,
                      output logic oe_end);
    rd = 24'h000000;
    ticks(1);
    frame_sel_n_o <= 1'b0;
    ticks(4);
    for (int i = nbits - 1; i >= 0; i--)
    begin
      sclk_o <= 1'b1;          // block launches its bit here
      serial_in_o <= word[i];  // held 40 ns either side of the fall
      ticks(4);
      sclk_o <= 1'b0;
      ticks(2);
      rd = {rd[22:0], serial_out_i};  // sample in mid low phase
      ticks(2);
    end
    oe_mid = serial_out_oe_i;
    frame_sel_n_o <= 1'b1;
    serial_in_o <= ~serial_in_o;  // released line shows no stale bit
    ticks(8);                     // also the minimum high time
    oe_end = serial_out_oe_i;
  endtask
endmodule

// ===== sim/test_dac_load_ctrl.sv
// self-checking bench for the serial dac load control block
`timescale 1ns/1ns
module test_dac_load_ctrl;
  import dac_load_pkg::*;
  typedef struct packed
  {
    logic [19:0] code;  // expected dac register
    logic [19:0] line;  // expected straight binary code
  } upd_type;
  logic        mclk, rst, ce, load_n, clr_n, dev_rst_n;  // bench drives
  logic        sclk, frame_sel_n, serial_in;            // host drives
  logic        serial_out, serial_out_oe, twos_mode;     // block outputs
  logic        dac_update, word_space;                   // block flags
  logic [19:0] dac_code, line_code, v, c, keep;          // codes
  logic [23:0] rd_word;                                  // readback
  logic        oe_mid, oe_end;                           // enable samples
  upd_type     exp_q[$];                                 // expected updates
  upd_type     e;                                        // popped note
  int          n_errors, compares;                       // tallies

  // device under test
  dac_load_ctrl dut (.mclk_i(mclk), .sys_rst_i(rst), .ce_i(ce),
    .sclk_i(sclk), .frame_sel_n_i(frame_sel_n), .serial_in_i(serial_in),
    .load_output_n_i(load_n), .clear_to_preset_n_i(clr_n),
    .dev_reset_n_i(dev_rst_n), .serial_out_o(serial_out),
    .serial_out_oe_o(serial_out_oe), .dac_code_o(dac_code),
    .line_code_o(line_code), .twos_mode_o(twos_mode),
    .dac_update_o(dac_update), .word_space_o(word_space));

  // far side host
  host_serial_model host (.mclk_i(mclk), .sclk_o(sclk),
    .frame_sel_n_o(frame_sel_n), .serial_in_o(serial_in),
    .serial_out_i(serial_out), .serial_out_oe_i(serial_out_oe));

  always #5 mclk = ~mclk;

  task automatic ticks(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // compare one flag
  task automatic check_bit(input string nm, input logic x, input logic g);
    compares++;
    if (g !== x)
    begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", nm, x, g);
    end
  endtask

  // compare one dac code
  task automatic check_code(input string nm, input logic [19:0] x,
                            input logic [19:0] g);
    compares++;
    if (g !== x)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask

  // compare one serial word
  task automatic check_word(input string nm, input logic [23:0] x,
                            input logic [23:0] g);
    compares++;
    if (g !== x)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask

  // one write frame of 24 bits
  task automatic write(input logic [2:0] a, input logic [19:0] d);
    host.send({1'b0, a, d}, 24, rd_word, oe_mid, oe_end);
  endtask

  task automatic stop_test();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watcher: each update pulse takes the oldest note
  always @(posedge mclk)
    if (!rst && dac_update === 1'b1)
    begin
      if (exp_q.size() == 0)
        check_bit("dac_update", 1'b0, 1'b1);
      else
      begin
        e = exp_q.pop_front();
        check_code("dac_code", e.code, dac_code);
        check_code("line_code", e.line, line_code);
      end
    end

  // hang guard, ten times the expected run
  initial
  begin
    #400000;
    n_errors++;
    stop_test();
  end

  // main sequence
  initial
  begin
    mclk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    load_n = 1'b0;
    clr_n = 1'b1;
    dev_rst_n = 1'b1;
    n_errors = 0;
    compares = 0;
    void'($urandom(33));
    ticks(8);
    rst <= 1'b0;
    ticks(4);
    check_code("dac_code", DAC_RST, dac_code);
    check_bit("serial_out_oe", 1'b0, serial_out_oe);
    $display("test reset done");
    // write with load held low, after stray clocks outside a frame
    host.noise();
    v = 20'($urandom());
    exp_q.push_back({v, v});
    write(ADDR_DAC, v);
    check_bit("oe_mid", 1'b1, oe_mid);
    check_bit("oe_end", 1'b0, oe_end);
    $display("test direct write done");
    // short frame is discarded
    host.send({1'b0, ADDR_DAC, ~v}, 23, rd_word, oe_mid, oe_end);
    ticks(10);
    check_code("dac_code", v, dac_code);
    $display("test short frame done");
    // load high defers the update to its fall
    load_n <= 1'b1;
    v = 20'($urandom());
    write(ADDR_DAC, v);
    ticks(10);
    exp_q.push_back({v, v});
    load_n <= 1'b0;
    ticks(10);
    load_n <= 1'b1;
    check_bit("pending", 1'b0, exp_q.size() != 0);
    $display("test deferred load done");
    // clear code in two's coding, then fill the buffer while clear stalls
    c = 20'($urandom());
    write(ADDR_CLR, c);
    write(ADDR_CTRL, 20'h00002);
    check_bit("twos_mode", 1'b1, twos_mode);
    exp_q.push_back({c, c ^ 20'h80000});
    clr_n <= 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      if (i == 8)
        check_bit("word_space", 1'b0, word_space);
      v = 20'($urandom());
      if (i == 7)
        keep = v;
      write(ADDR_DAC, v);
    end
    check_code("dac_code", c, dac_code);
    clr_n <= 1'b1;
    ticks(30);
    check_bit("word_space", 1'b1, word_space);
    exp_q.push_back({keep, keep ^ 20'h80000});
    load_n <= 1'b0;
    ticks(10);
    load_n <= 1'b1;
    check_bit("pending", 1'b0, exp_q.size() != 0);
    $display("test clear and buffer done");
    // readback of the clear code in the following frame
    host.send({1'b1, ADDR_CLR, 20'h00000}, 24, rd_word, oe_mid, oe_end);
    host.send({1'b1, ADDR_CTRL, 20'h00000}, 24, rd_word, oe_mid, oe_end);
    check_word("readback", {1'b1, ADDR_CLR, c}, rd_word);
    $display("test readback done");
    // clock enable low freezes the block through a whole frame
    exp_q.push_back({keep, keep ^ 20'h80000});
    load_n <= 1'b0;
    ticks(10);
    ce <= 1'b0;
    write(ADDR_DAC, ~keep);
    ce <= 1'b1;
    ticks(10);
    check_code("dac_code", keep, dac_code);
    check_bit("pending", 1'b0, exp_q.size() != 0);
    $display("test clock enable done");
    // reset pin restores power-on state
    dev_rst_n <= 1'b0;
    ticks(4);
    dev_rst_n <= 1'b1;
    ticks(6);
    check_code("dac_code", DAC_RST, dac_code);
    check_bit("twos_mode", 1'b0, twos_mode);
    $display("test device reset done");
    stop_test();
  end
endmodule
